// file: design/agb_port.sv
// Graphics port PCI-protocol bridge: target, initiator, upstream FIFO
`timescale 1ns/1ps
`default_nettype none
`include "agb_consts.svh"
// How it works
// - A memory read that latches the read slot goes upstream as a snoop read of cpl_len dwords.
// - Only linear bursts; other orderings disconnect after first data phase.
// - Completion data only to a read matching latched address and enables.
// - Valid completion starts 2^15 clock timer; expiry discards and clears.
// - I/O reads and I/O writes are never claimed.
// - Inbound memory writes are posted and forwarded toward memory only.
// - Write snoop is zero-length read-invalidate; writeback merges upstream.
// - Plain write forwards one packet up to line end, buffer limit or master disconnect.
// - Retry on pending read, low space, host lock, or busy read slot.
// - Read disconnects at end of buffered data or on non-linear burst.
// - Write disconnects when buffers run out or at line boundary.
// - Outbound reads are queued, four requests at most.
// - Retried outbound read is reissued; posted writes pass meanwhile.
// - Outbound reads finish in queue order; later reads wait.
// - Sequential outbound writes merge into one burst when enabled.
// - Plain write merges only at 4, 8 or 16 dwords for 1X, 2X, 4X.
// - Write-invalidate burst extends only by full lines, else ends.
// - Plain write burst never ends to switch to write-invalidate.
// - Accept fast back-to-back as target; never make it as initiator.
// - No speculative prefetch beyond the requested read.
// - Read without buffered data is retried within three clocks of frame.
// - One delayed read request slot, so one outstanding delayed read.

//----------------------------------------------------------------------
// Upstream FIFO
//----------------------------------------------------------------------
module agb_fifo #(
    parameter int W  = `AGB_FIFO_W,
    parameter int D  = `AGB_FIFO_D,
    parameter int AW = `AGB_FIFO_AW
) (
    // Clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    // Fill side
    input  wire logic          i_valid,
    input  wire logic [W-1:0]  i_data,
    output logic               o_ready,
    // Drain side
    output logic               o_valid,
    output logic [W-1:0]       o_data,
    input  wire logic          i_ready,
    // Fill level
    output logic [AW:0]        o_count
);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } agb_fifo_st_t;

    agb_fifo_st_t s;
    agb_fifo_st_t n;
    logic         push;
    logic         pop;

    // Honest full and empty flags
    assign o_ready = s.cnt != (AW+1)'(D);
    assign o_valid = s.cnt != '0;
    assign o_data  = s.mem[s.rp];
    assign o_count = s.cnt;
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    // Pointer and level update
    always_comb
    begin
        n = s;
        if (push)
        begin
            n.mem[s.wp] = i_data;
            n.wp        = s.wp + 1'b1;
        end
        if (pop)
            n.rp = s.rp + 1'b1;
        n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            s <= '0;
        else
            s <= n;
    end
endmodule : agb_fifo

//----------------------------------------------------------------------
// Bridge port
//----------------------------------------------------------------------
module agb_port #(
    parameter int P_DISCARD_CLK = `AGB_DISCARD_CLK
) (
    // Clock and reset
    input  wire logic        I_CLOCK,
    input  wire logic        I_SYS_RST,
    // Inbound target side
    input  wire logic        I_TGT_FRAME,
    input  wire logic [3:0]  I_TGT_CMD,
    input  wire logic [31:0] I_TGT_ADDR,
    input  wire logic [3:0]  I_TGT_BE,
    input  wire logic        I_TGT_DVLD,
    input  wire logic [31:0] I_TGT_WDATA,
    input  wire logic        I_TGT_LAST,
    output logic             O_TGT_CLAIM,
    output logic             O_TGT_TRDY,
    output logic             O_TGT_DISC,
    output logic             O_TGT_RETRY,
    output logic [31:0]      O_TGT_RDATA,
    // Control levels
    input  wire logic        I_HOST_LOCK,
    input  wire logic        I_COMBINE_EN,
    input  wire logic [1:0]  I_XFER_MODE,
    // Upstream packets
    output logic             O_UP_VALID,
    input  wire logic        I_UP_READY,
    output logic [1:0]       O_UP_CMD,
    output logic [3:0]       O_UP_LEN,
    output logic [31:0]      O_UP_DATA,
    output logic [3:0]       O_UP_BE,
    output logic             O_UP_LAST,
    // Read data return
    input  wire logic        I_DN_VALID,
    input  wire logic [31:0] I_DN_DATA,
    input  wire logic        I_DN_LAST,
    output logic             O_CPL_DISCARD,
    // Outbound requests
    input  wire logic        I_OB_VALID,
    output logic             O_OB_READY,
    input  wire logic        I_OB_WRITE,
    input  wire logic        I_OB_MWI,
    input  wire logic [31:0] I_OB_ADDR,
    input  wire logic [7:0]  I_OB_LEN,
    // Initiator side
    output logic             O_INI_REQ,
    output logic             O_INI_WRITE,
    output logic             O_INI_MWI,
    output logic [31:0]      O_INI_ADDR,
    output logic [7:0]       O_INI_LEN,
    input  wire logic        I_INI_DONE,
    input  wire logic        I_INI_RETRY
);
    agb_pkg::agb_state_t s;
    agb_pkg::agb_state_t n;
    logic                     fi_valid;
    logic                     fi_ready;
    logic [`AGB_FIFO_W-1:0]   fi_data;
    logic [`AGB_FIFO_W-1:0]   fo_data;
    logic [`AGB_FIFO_AW:0]    fi_count;
    logic [4:0]               free;
    logic                     is_rd;
    logic                     is_wr;
    logic                     hit;
    logic [2:0]               idx;
    logic [2:0]               dstart;
    logic [2:0]               dend;
    logic [7:0]               thr;
    logic                     seq;
    logic                     merge;
    logic                     push_rd;
    logic                     pop_rd;
    logic [8:0]               msum;

    // Upstream FIFO instance
    agb_fifo #(
        .W  (`AGB_FIFO_W),
        .D  (`AGB_FIFO_D),
        .AW (`AGB_FIFO_AW)
    ) u_fifo (
        .i_clk   (I_CLOCK),
        .i_rst   (I_SYS_RST),
        .i_valid (fi_valid),
        .i_data  (fi_data),
        .o_ready (fi_ready),
        .o_valid (O_UP_VALID),
        .o_data  (fo_data),
        .i_ready (I_UP_READY),
        .o_count (fi_count)
    );

    // Output mapping
    assign {O_UP_LAST, O_UP_CMD, O_UP_LEN, O_UP_DATA, O_UP_BE} = fo_data;
    assign O_TGT_RDATA   = s.rdata;
    assign O_CPL_DISCARD = s.discard;
    assign O_INI_REQ     = s.ist == agb_pkg::AGB_I_BUSY;
    assign O_INI_WRITE   = s.ini_wr;
    assign O_INI_MWI     = s.ini_mwi;
    assign O_INI_ADDR    = s.ini_addr;
    assign O_INI_LEN     = s.ini_len;
    // I/O commands fall outside both classes, never claimed
    assign is_rd = s.tcmd == `AGB_CMD_MR || s.tcmd == `AGB_CMD_MRM ||
                   s.tcmd == `AGB_CMD_MRL;
    assign is_wr = s.tcmd == `AGB_CMD_MW || s.tcmd == `AGB_CMD_MWI;
    assign O_TGT_CLAIM = (s.tst == agb_pkg::AGB_T_DEC && (is_rd || is_wr))
                      || s.tst == agb_pkg::AGB_T_RD
                      || s.tst == agb_pkg::AGB_T_WR;
    // Completion goes only to matching address and enables
    assign hit    = s.drr_v && s.drr_addr == {s.taddr[31:2], 2'b00} &&
                    s.drr_be == s.tbe;
    assign free   = `AGB_FIFO_FULL - fi_count;
    assign idx    = s.taddr[4:2];
    assign dstart = s.drr_addr[4:2];
    assign dend   = 3'(dstart + s.cpl_len[2:0] - 3'h1);

    // Combining threshold and sequential check
    assign thr  = (I_XFER_MODE == 2'h2) ? `AGB_THR_4X :
                  (I_XFER_MODE == 2'h1) ? `AGB_THR_2X : `AGB_THR_1X;
    assign seq  = 32'(s.waddr + {22'h0, s.wlen, 2'b00}) == I_OB_ADDR;
    assign msum = {1'b0, s.wlen} + {1'b0, I_OB_LEN};
    // Merge only into a pending, unissued burst
    assign merge = s.comb_en && s.wv && !s.wiss && I_OB_WRITE && seq &&
                   !msum[8] &&
                   (s.wmwi ? (I_OB_MWI && I_OB_LEN == `AGB_LINE_DW)
                           : (s.wlen >= thr));
    // Read queue holds four at most
    assign O_OB_READY = I_OB_WRITE ? (!s.wv || merge)
                                   : (s.rq_cnt != `AGB_RDQ_FULL);

    // Target, delayed read and initiator next state
    always_comb
    begin
        n           = s;
        n.discard   = 1'b0;
        fi_valid    = 1'b0;
        fi_data     = '0;
        O_TGT_TRDY  = 1'b0;
        O_TGT_DISC  = 1'b0;
        O_TGT_RETRY = 1'b0;
        push_rd     = 1'b0;
        pop_rd      = 1'b0;
        n.comb_en   = I_COMBINE_EN;
        // Completion data fills the line buffer
        if (I_DN_VALID && s.drr_v && !s.cpl_v)
        begin
            n.cpl_buf[3'(dstart + s.cpl_wi)] = I_DN_DATA;
            n.cpl_wi = s.cpl_wi + 3'h1;
            if (I_DN_LAST)
            begin
                n.cpl_v   = 1'b1;
                n.cpl_tmr = '0;
            end
        end
        // Discard timer on an unclaimed completion
        if (s.cpl_v && s.tst != agb_pkg::AGB_T_RD &&
            s.tst != agb_pkg::AGB_T_DEC)
        begin
            if (s.cpl_tmr == 16'(P_DISCARD_CLK - 1))
            begin
                n.drr_v   = 1'b0;
                n.cpl_v   = 1'b0;
                n.discard = 1'b1;
            end
            else
                n.cpl_tmr = s.cpl_tmr + 16'h1;
        end
        unique case (s.tst)
            agb_pkg::AGB_T_IDLE:
            begin
                // Frame taken in any idle cycle
                if (I_TGT_FRAME)
                begin
                    n.tcmd  = I_TGT_CMD;
                    n.taddr = I_TGT_ADDR;
                    n.tbe   = I_TGT_BE;
                    n.tlin  = I_TGT_ADDR[1:0] == 2'b00;
                    n.tst   = agb_pkg::AGB_T_DEC;
                end
            end
            agb_pkg::AGB_T_DEC:
            begin
                n.tst = agb_pkg::AGB_T_IDLE;
                if (is_rd)
                begin
                    // Retry one clock after frame
                    O_TGT_RETRY = 1'b1;
                    if (I_HOST_LOCK)
                        O_TGT_RETRY = 1'b1;
                    else if (hit && s.cpl_v)
                    begin
                        O_TGT_RETRY = 1'b0;
                        n.tst       = agb_pkg::AGB_T_RD;
                    end
                    else if (!s.drr_v && free != 5'h0)
                    begin
                        // Single slot latched, snoop read sent
                        n.drr_v    = 1'b1;
                        n.cpl_v    = 1'b0;
                        n.cpl_wi   = 3'h0;
                        n.drr_addr = {s.taddr[31:2], 2'b00};
                        n.drr_be   = s.tbe;
                        // Fetch only what was asked
                        if (s.tcmd == `AGB_CMD_MR)
                            n.cpl_len = (idx == `AGB_LINE_LAST) ? 4'h1 : 4'h2;
                        else
                            n.cpl_len = 4'h8 - {1'b0, idx};
                        fi_valid = 1'b1;
                        fi_data  = {1'b1, agb_pkg::AGB_UP_RD_SNOOP0,
                                    n.cpl_len, n.drr_addr, s.tbe};
                    end
                end
                else if (is_wr)
                begin
                    // Posting space: a line for invalidate
                    if (I_HOST_LOCK || free < ((s.tcmd == `AGB_CMD_MWI)
                        ? 5'h9 : 5'h2))
                        O_TGT_RETRY = 1'b1;
                    else
                    begin
                        // Posted write header toward memory
                        fi_valid = 1'b1;
                        fi_data  = {1'b0, (s.tcmd == `AGB_CMD_MWI) ?
                                    agb_pkg::AGB_UP_LINE_WR :
                                    agb_pkg::AGB_UP_WR_SNOOP_INV0, 4'h0,
                                    {s.taddr[31:2], 2'b00}, s.tbe};
                        n.tst    = agb_pkg::AGB_T_WR;
                    end
                end
            end
            agb_pkg::AGB_T_RD:
            begin
                // Stream buffer; stop at its end or on non-linear
                O_TGT_TRDY = 1'b1;
                O_TGT_DISC = (idx == dend) || !s.tlin;
                if (I_TGT_DVLD)
                begin
                    n.taddr = s.taddr + 32'h4;
                    if (O_TGT_DISC || I_TGT_LAST)
                    begin
                        n.drr_v = 1'b0;
                        n.cpl_v = 1'b0;
                        n.tst   = agb_pkg::AGB_T_IDLE;
                    end
                end
            end
            agb_pkg::AGB_T_WR:
            begin
                // Stop at line end or last buffer
                O_TGT_TRDY = free != 5'h0;
                O_TGT_DISC = (idx == `AGB_LINE_LAST) || (free == 5'h1) ||
                             !s.tlin;
                if (I_TGT_DVLD && O_TGT_TRDY)
                begin
                    // Packet ends at line or disconnect
                    fi_valid = 1'b1;
                    fi_data  = {O_TGT_DISC || I_TGT_LAST,
                                agb_pkg::AGB_UP_DATA, 4'h0, I_TGT_WDATA,
                                I_TGT_BE};
                    n.taddr  = s.taddr + 32'h4;
                    if (O_TGT_DISC || I_TGT_LAST)
                        n.tst = agb_pkg::AGB_T_IDLE;
                end
            end
        endcase
        n.rdata = n.cpl_buf[n.taddr[4:2]];
        // Outbound request intake
        if (I_OB_VALID && O_OB_READY)
        begin
            if (!I_OB_WRITE)
            begin
                push_rd         = 1'b1;
                n.rq[s.rq_wp]   = {I_OB_ADDR, I_OB_LEN};
                n.rq_wp         = s.rq_wp + 2'h1;
            end
            else if (merge)
                n.wlen = msum[7:0];
            else
            begin
                n.wv    = 1'b1;
                n.wiss  = 1'b0;
                n.waddr = I_OB_ADDR;
                n.wlen  = I_OB_LEN;
                n.wmwi  = I_OB_MWI;
            end
        end
        unique case (s.ist)
            agb_pkg::AGB_I_IDLE:
            begin
                // Posted write passes a waiting read
                if (s.wv && !s.wiss)
                begin
                    n.ini_wr   = 1'b1;
                    n.ini_mwi  = s.wmwi;
                    n.ini_addr = s.waddr;
                    n.ini_len  = n.wlen;  // Includes a same-cycle merge
                    n.wiss     = 1'b1;
                    n.ist      = agb_pkg::AGB_I_BUSY;
                end
                else if (s.rq_cnt != 3'h0)
                begin
                    // Only the queue head is issued
                    n.ini_wr                  = 1'b0;
                    n.ini_mwi                 = 1'b0;
                    {n.ini_addr, n.ini_len}   = s.rq[s.rq_rp];
                    n.ist                     = agb_pkg::AGB_I_BUSY;
                end
            end
            agb_pkg::AGB_I_BUSY:
            begin
                if (I_INI_DONE)
                begin
                    if (s.ini_wr)
                        n.wv = 1'b0;
                    else
                    begin
                        pop_rd  = 1'b1;
                        n.rq_rp = s.rq_rp + 2'h1;
                    end
                    n.ist = agb_pkg::AGB_I_GAP;
                end
                else if (I_INI_RETRY)
                begin
                    // Retried head stays for reissue
                    if (s.ini_wr)
                        n.wiss = 1'b0;
                    n.ist = agb_pkg::AGB_I_GAP;
                end
            end
            agb_pkg::AGB_I_GAP:
                n.ist = agb_pkg::AGB_I_IDLE;
        endcase
        n.rq_cnt = s.rq_cnt + 3'(push_rd) - 3'(pop_rd);
    end

    // State register
    always_ff @(posedge I_CLOCK)
    begin
        if (I_SYS_RST)
            s <= '0;
        else
            s <= n;
    end

    // Checks
    AST_RD_RETRY3: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        s.tst == agb_pkg::AGB_T_IDLE && I_TGT_FRAME &&
        I_TGT_CMD == `AGB_CMD_MR |-> ##[1:3] (O_TGT_RETRY || O_TGT_TRDY))
        else $error("read not answered within three clocks");
    AST_IO_UNCLAIMED: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        s.tst == agb_pkg::AGB_T_IDLE && I_TGT_FRAME &&
        (I_TGT_CMD == `AGB_CMD_IOR || I_TGT_CMD == `AGB_CMD_IOW)
        |=> !O_TGT_CLAIM ##1 !O_TGT_CLAIM)
        else $error("io cycle claimed");
    AST_NONLIN_DISC: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        O_TGT_TRDY && !s.tlin |-> O_TGT_DISC)
        else $error("non-linear burst not disconnected");
    AST_WR_LINE_DISC: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        s.tst == agb_pkg::AGB_T_WR && O_TGT_TRDY && s.taddr[4:2] == 3'h7
        |-> O_TGT_DISC)
        else $error("write crossed line boundary");
    AST_ONE_DRR: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        fi_valid && fi_data[41:40] == agb_pkg::AGB_UP_RD_SNOOP0
        |-> !s.drr_v ##1 s.drr_v)
        else $error("second delayed read issued");
    AST_DISCARD: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        O_CPL_DISCARD |-> !s.drr_v && !s.cpl_v && $past(s.cpl_v, 1))
        else $error("discard did not clear slot");
    AST_HIT_DATA: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        $rose(s.tst == agb_pkg::AGB_T_RD) |-> $past(hit && s.cpl_v, 1))
        else $error("completion served without match");
    AST_RDQ_MAX: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        s.rq_cnt == 3'h4 && !I_OB_WRITE |-> !O_OB_READY ##1 s.rq_cnt <= 3'h4)
        else $error("read queue overrun");
    AST_NO_FB2B: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        $fell(O_INI_REQ) |-> !O_INI_REQ ##1 !O_INI_REQ)
        else $error("back-to-back initiator cycle");
    AST_IN_ORDER: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
        O_INI_REQ && I_INI_RETRY && !O_INI_WRITE |=> $stable(s.rq_rp))
        else $error("retried read left the queue");
endmodule : agb_port
`default_nettype wire

// file: pkg/agb_consts.svh
// Constants of the graphics port bridge: commands, sizes, timing
`ifndef AGB_CONSTS_SVH
`define AGB_CONSTS_SVH
// Bus commands
`define AGB_CMD_IOR     4'h2
`define AGB_CMD_IOW     4'h3
`define AGB_CMD_MR      4'h6
`define AGB_CMD_MW      4'h7
`define AGB_CMD_MRM     4'hc
`define AGB_CMD_MRL     4'he
`define AGB_CMD_MWI     4'hf
// Cache line in dwords, last dword index in a line
`define AGB_LINE_DW     8'h08
`define AGB_LINE_LAST   3'h7
// Completion discard time in clocks
`define AGB_DISCARD_CLK 32768
// Combining thresholds in dwords for 1X, 2X, 4X
`define AGB_THR_1X      8'h04
`define AGB_THR_2X      8'h08
`define AGB_THR_4X      8'h10
// Upstream FIFO and outbound read queue
`define AGB_FIFO_W      43
`define AGB_FIFO_D      16
`define AGB_FIFO_AW     4
`define AGB_FIFO_FULL   5'h10
`define AGB_RDQ_FULL    3'h4
`endif

// file: pkg/agb_pkg.sv
// Types of the graphics port bridge
`default_nettype none
package agb_pkg;
    typedef enum logic [1:0] {AGB_T_IDLE, AGB_T_DEC, AGB_T_RD, AGB_T_WR}
        agb_tst_t;
    typedef enum logic [1:0] {AGB_I_IDLE, AGB_I_BUSY, AGB_I_GAP} agb_ist_t;
    typedef enum logic [1:0] {AGB_UP_RD_SNOOP0, AGB_UP_WR_SNOOP_INV0,
                              AGB_UP_LINE_WR, AGB_UP_DATA} agb_up_t;
    typedef struct packed {
        agb_tst_t        tst;
        logic [3:0]      tcmd;
        logic [31:0]     taddr;
        logic [3:0]      tbe;
        logic            tlin;
        logic            drr_v;
        logic            cpl_v;
        logic [31:0]     drr_addr;
        logic [3:0]      drr_be;
        logic [3:0]      cpl_len;
        logic [2:0]      cpl_wi;
        logic [7:0][31:0] cpl_buf;
        logic [15:0]     cpl_tmr;
        logic            discard;
        logic [31:0]     rdata;
        logic            comb_en;
        agb_ist_t        ist;
        logic [3:0][39:0] rq;
        logic [1:0]      rq_rp;
        logic [1:0]      rq_wp;
        logic [2:0]      rq_cnt;
        logic            wv;
        logic            wiss;
        logic            wmwi;
        logic [31:0]     waddr;
        logic [7:0]      wlen;
        logic            ini_wr;
        logic            ini_mwi;
        logic [31:0]     ini_addr;
        logic [7:0]      ini_len;
    } agb_state_t;
endpackage : agb_pkg
`default_nettype wire

// file: test/agb_card_model.sv
// Graphics card model that answers outbound bus requests
`timescale 1ns/1ps
`default_nettype none
module agb_card_model (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Request and retry budget
    input  wire logic       i_req,
    input  wire logic [1:0] i_n_retry,
    // Answers
    output logic            o_done,
    output logic            o_retry
);
    logic [1:0] w_ff;
    logic [1:0] n_ff;
    // Answer three clocks into a request, retrying the first i_n_retry of every four answers
    always_ff @(posedge i_clk)
    begin
        o_done  <= 1'b0;
        o_retry <= 1'b0;
        w_ff    <= (i_req && !o_done && !o_retry) ? w_ff + 2'h1 : 2'h0;
        if (i_rst)
            n_ff <= 2'h0;
        else if (w_ff == 2'h2)
        begin
            o_retry <= (n_ff < i_n_retry);
            o_done  <= !(n_ff < i_n_retry);
            n_ff    <= n_ff + 2'h1;
        end
    end
endmodule : agb_card_model
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench of the graphics port bridge
`timescale 1ns/1ps
`default_nettype none
`include "agb_consts.svh"
module testbench;
    logic clk = 1'b0, rst = 1'b1, fr = 1'b0, dv = 1'b0, la = 1'b0;
    logic [3:0] cmd = 4'h0, be = 4'hf;
    logic [31:0] ad = 32'h0, wd = 32'h0, dd = 32'h0, rd, ia;
    logic dnv = 1'b0, dnl = 1'b0, obv = 1'b0, obw = 1'b0, obr, ur = 1'b1;
    logic cl, tr, rt, uv, iq, idn, irt, iq_q = 1'b0;
    logic lk = 1'b0, dsc, ulst, dc;
    logic [1:0] uc, nr = 2'h0;
    logic [3:0] ul;
    logic [6:0] uq[$];
    logic [31:0] lg[$];
    int n_fail = 0, check_count = 0;
    agb_port #(.P_DISCARD_CLK(16)) i_dut (.I_CLOCK(clk), .I_SYS_RST(rst),
        .I_TGT_FRAME(fr), .I_TGT_CMD(cmd), .I_TGT_ADDR(ad), .I_TGT_BE(be),
        .I_TGT_DVLD(dv), .I_TGT_WDATA(wd), .I_TGT_LAST(la), .O_TGT_CLAIM(cl),
        .O_TGT_TRDY(tr), .O_TGT_DISC(dsc), .O_TGT_RETRY(rt), .O_TGT_RDATA(rd),
        .I_HOST_LOCK(lk), .I_COMBINE_EN(1'b0), .I_XFER_MODE(2'h0),
        .O_UP_VALID(uv), .I_UP_READY(ur), .O_UP_CMD(uc), .O_UP_LEN(ul),
        .O_UP_DATA(), .O_UP_BE(), .O_UP_LAST(ulst), .I_DN_VALID(dnv),
        .I_DN_DATA(dd), .I_DN_LAST(dnl), .O_CPL_DISCARD(dc), .I_OB_VALID(obv),
        .O_OB_READY(obr), .I_OB_WRITE(obw), .I_OB_MWI(1'b0), .I_OB_ADDR(ad),
        .I_OB_LEN(8'h08), .O_INI_REQ(iq), .O_INI_WRITE(), .O_INI_MWI(),
        .O_INI_ADDR(ia), .O_INI_LEN(), .I_INI_DONE(idn), .I_INI_RETRY(irt));
    agb_card_model i_card (.i_clk(clk), .i_rst(rst), .i_req(iq),
        .i_n_retry(nr), .o_done(idn), .o_retry(irt));
    // Clock and logs of upstream words and request addresses
    initial forever #20 clk = ~clk;
    always @(posedge clk)
    begin
        if (uv && ur) uq.push_back({ulst, uc, ul});
        if (iq && !iq_q) lg.push_back(ia);
        iq_q <= iq;
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Bounded wait for a condition sampled before each edge
    task automatic wt(ref logic s);
        int i;
        for (i = 0; i < 200 && s !== 1'b1; i++) @(negedge clk);
        if (i == 200) begin n_fail++; summarize(); end
    endtask : wt
    task automatic frm(logic [3:0] c, logic [31:0] a, logic [3:0] b);
        @(posedge clk) #1 {fr, cmd, ad, be} = {1'b1, c, a, b};
        @(posedge clk) #1 fr = 1'b0;
    endtask : frm
    task automatic phase(logic [31:0] d, logic e);
        {dv, la, wd} = {2'b11, d};
        wt(tr);
        chk("disconnect", {31'h0, e}, {31'h0, dsc});
        @(posedge clk) #1 {dv, la} = 2'b00;
    endtask : phase
    task automatic upchk(logic [6:0] e);
        int i;
        for (i = 0; i < 50 && uq.size() == 0; i++) @(posedge clk);
        chk("upstream", {25'h0, e},
            (uq.size() > 0) ? {25'h0, uq.pop_front()} : '1);
    endtask : upchk
    task automatic t_io;
        frm(`AGB_CMD_IOR, 32'h40, 4'hf);
        chk("io read claim", 32'h0, {31'h0, cl | rt});
        frm(`AGB_CMD_IOW, 32'h40, 4'hf);
        chk("io write claim", 32'h0, {31'h0, cl | rt});
    endtask : t_io
    task automatic t_read;
        frm(`AGB_CMD_MR, 32'h100, 4'hf);
        chk("read retry", 32'h1, {31'h0, rt});
        upchk({1'b1, 2'h0, 4'h2});
        @(posedge clk) #1 {dnv, dd} = {1'b1, 32'hcafe0001};
        @(posedge clk) #1 {dnl, dd} = {1'b1, 32'hcafe0002};
        @(posedge clk) #1 {dnv, dnl} = 2'b00;
        repeat (2) @(posedge clk);
        frm(`AGB_CMD_MR, 32'h100, 4'h3);
        chk("enable mismatch", 32'h1, {31'h0, rt});
        frm(`AGB_CMD_MR, 32'h100, 4'hf);
        chk("match claim", 32'h1, {31'h0, cl});
        {dv, la} = 2'b11;
        wt(tr);
        chk("read data", 32'hcafe0001, rd);
        @(posedge clk) #1 {dv, la} = 2'b00;
    endtask : t_read
    // Completion left unclaimed is dropped and its slot freed
    task automatic t_disc;
        int i;
        frm(`AGB_CMD_MRL, 32'h11c, 4'hf);
        chk("line read retry", 32'h1, {31'h0, rt});
        upchk({1'b1, 2'h0, 4'h1});
        @(posedge clk) #1 {dnv, dnl, dd} = {2'b11, 32'hbeef0007};
        @(posedge clk) #1 {dnv, dnl} = 2'b00;
        for (i = 0; i < 40 && dc !== 1'b1; i++) @(negedge clk);
        chk("discard", 32'h1, {31'h0, dc});
        frm(`AGB_CMD_MRL, 32'h11c, 4'hf);
        chk("slot cleared", 32'h1, {31'h0, rt});
        upchk({1'b1, 2'h0, 4'h1});
    endtask : t_disc
    task automatic t_write;
        @(posedge clk) #1 lk = 1'b1;
        frm(`AGB_CMD_MW, 32'h21c, 4'hf);
        chk("lock retry", 32'h1, {31'h0, rt});
        @(posedge clk) #1 lk = 1'b0;
        frm(`AGB_CMD_MW, 32'h21c, 4'hf);
        chk("write claim", 32'h1, {31'h0, cl});
        phase(32'h5a5a0001, 1'b1);
        upchk({1'b0, 2'h1, 4'h0});
        upchk({1'b1, 2'h3, 4'h0});
    endtask : t_write
    // Master's full aligned line, forwarded as one line
    task automatic t_mwi;
        int i;
        frm(`AGB_CMD_MWI, 32'h240, 4'hf);
        chk("line write claim", 32'h1, {31'h0, cl});
        {dv, wd} = {1'b1, 32'h0};
        for (i = 0; i < 8; i++)
        begin
            wt(tr);
            chk("line disc", {31'h0, i == 7}, {31'h0, dsc});
            @(posedge clk) #1 wd = wd + 32'h1;
        end
        dv = 1'b0;
        upchk({1'b0, 2'h2, 4'h0});
        for (i = 0; i < 8; i++) upchk({i == 7, 2'h3, 4'h0});
    endtask : t_mwi
    task automatic t_ob;
        int a;
        nr = 2'h1;
        for (a = 1; a < 3; a++)
        begin
            @(posedge clk) #1 {obv, ad} = {1'b1, 32'(a * 32'h1000)};
            wt(obr);
            @(posedge clk) #1 obv = 1'b0;
        end
        for (a = 0; a < 200 && lg.size() < 3; a++) @(posedge clk);
        chk("reissue", 32'h1000, (lg.size() > 1) ? lg[1] : '1);
        chk("order", 32'h2000, (lg.size() > 2) ? lg[2] : '1);
    endtask : t_ob
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        chk("ob ready", 32'h1, {31'h0, obr});
        t_io();
        t_read();
        t_disc();
        t_write();
        t_mwi();
        t_ob();
        summarize();
    end
endmodule : testbench
`default_nettype wire
